// ==== hdl/stack_pointer_limit_checker.sv ====
/*
  Stack pointer, stack limit and stack error trap for a 16-bit core.
  Assumes the core issues one stack operation per cycle and takes the trap request as a level.
*/
`include "stack_params.svh"
module stack_pointer_limit_checker
(
  input wire ref_clk, // CPU clock
  input wire srst, // Synchronous reset, active high
  input wire stack_pkg::stack_op_t op, // Stack operation this cycle
  input wire stack_pkg::word_t offset, // Extra offset for plain accesses
  input wire pc_push_call, // Push of a call return address
  input wire pc_push_exc, // Push of an exception return address
  input wire [23:0] pc_in, // Program counter to push
  input wire [7:0] status_low_byte, // Low status byte
  input wire sp_wr, // Write to stack pointer
  input wire limit_wr, // Write to stack limit
  input wire stack_pkg::word_t wr_data, // Data for those writes
  output stack_pkg::word_t effective_address, // Address formed from the pointer
  output logic addr_valid, // Address is formed this cycle
  output logic [23:0] pc_push_data, // Program counter word as stacked
  output stack_pkg::word_t sp_out, // Current stack pointer
  output stack_pkg::word_t limit_out, // Current stack limit
  output logic stack_trap // Stack error trap request
);
  import stack_pkg::*;

  typedef struct packed {
    word_t stack_pointer_reg;
    word_t stack_limit_reg;
  } state_t;

  state_t st_reg;
  state_t st_next;
  logic over_limit;
  logic under_floor;

  // Address formed from the pointer: pop reads below, push writes at, access adds the offset
  always_comb
  begin
    case (op)
      op_pop: effective_address = st_reg.stack_pointer_reg - `STK_WORD_STEP;
      op_push: effective_address = st_reg.stack_pointer_reg;
      op_access: effective_address = st_reg.stack_pointer_reg + offset;
      default: effective_address = st_reg.stack_pointer_reg;
    endcase
  end
  assign addr_valid = op != op_none;

  // Limit and floor comparison of the formed address
  stack_bound_check u_check (
    .addr(effective_address),
    .limit(st_reg.stack_limit_reg),
    .over_limit(over_limit),
    .under_floor(under_floor)
  );

  // Push at the limit writes the limit word itself; traps come beyond the limit or below the floor
  assign stack_trap = addr_valid && (over_limit || under_floor);

  // Program counter as stored on the stack
  always_comb
  begin
    pc_push_data = pc_in;
    if (pc_push_exc)
    begin
      pc_push_data[`STK_PC_MSB_HI:`STK_PC_MSB_LO] = status_low_byte;
    end
    else if (pc_push_call)
    begin
      pc_push_data[`STK_PC_MSB_HI:`STK_PC_MSB_LO] = 8'h00;
    end
  end

  // Next state of pointer and limit
  always_comb
  begin
    st_next = st_reg;
    if (sp_wr)
    begin
      st_next.stack_pointer_reg = {wr_data[`STK_WIDTH-1:1], 1'b0};
    end
    else if (op == op_push)
    begin
      st_next.stack_pointer_reg = st_reg.stack_pointer_reg + `STK_WORD_STEP;
    end
    else if (op == op_pop)
    begin
      st_next.stack_pointer_reg = st_reg.stack_pointer_reg - `STK_WORD_STEP;
    end
    if (limit_wr)
    begin
      st_next.stack_limit_reg = {wr_data[`STK_WIDTH-1:1], 1'b0};
    end
    // Reset defines the pointer only; the limit keeps whatever it holds
    if (srst)
    begin
      st_next.stack_pointer_reg = `STK_SP_RESET;
    end
  end

  // Register the whole state every rising edge
  always_ff @(posedge ref_clk)
  begin
    st_reg <= st_next;
  end

  assign sp_out = st_reg.stack_pointer_reg;
  assign limit_out = st_reg.stack_limit_reg;

  // A push whose address equals the limit must not trap
  a_limit_equal_push: assert property (@(posedge ref_clk) disable iff (srst)
    (op == op_push && st_reg.stack_pointer_reg == st_reg.stack_limit_reg
     && st_reg.stack_pointer_reg >= `STK_FLOOR) |-> !stack_trap)
    else $error("push at limit trapped");

  // A push after the limit push traps
  a_beyond_limit_push: assert property (@(posedge ref_clk) disable iff (srst)
    (op == op_push && !sp_wr && st_reg.stack_pointer_reg == st_reg.stack_limit_reg
     && !limit_wr) ##1 (op == op_push) |-> stack_trap)
    else $error("push beyond limit did not trap");

  // Underflow below the floor traps
  a_floor_trap: assert property (@(posedge ref_clk) disable iff (srst)
    (addr_valid && effective_address < `STK_FLOOR) |-> stack_trap)
    else $error("underflow did not trap");

  // Push advances the pointer by one word
  a_push_step: assert property (@(posedge ref_clk) disable iff (srst)
    (op == op_push && !sp_wr) |=> sp_out == $past(sp_out) + `STK_WORD_STEP)
    else $error("push step wrong");

  // Pop reads the word below and retreats the pointer
  a_pop_step: assert property (@(posedge ref_clk) disable iff (srst)
    (op == op_pop && !sp_wr) |=> (sp_out == $past(effective_address)))
    else $error("pop step wrong");

  // Pointer and limit stay word aligned
  a_word_align: assert property (@(posedge ref_clk) disable iff (srst)
    (limit_wr || sp_wr) |=> (!limit_out[0] && !sp_out[0]))
    else $error("misaligned pointer or limit");

  // Call push clears the top byte
  a_call_msb: assert property (@(posedge ref_clk) disable iff (srst)
    (pc_push_call && !pc_push_exc) |-> pc_push_data[23:16] == 8'h00
      && pc_push_data[15:0] == pc_in[15:0])
    else $error("call push top byte not clear");

  // Exception push carries the status byte
  a_exc_msb: assert property (@(posedge ref_clk) disable iff (srst)
    pc_push_exc |-> pc_push_data[23:16] == status_low_byte)
    else $error("exception push top byte wrong");

  // No trap without a formed address
  a_trap_needs_addr: assert property (@(posedge ref_clk) disable iff (srst)
    stack_trap |-> addr_valid)
    else $error("trap without address");

  // Pointer comes out of reset at the floor
  a_sp_reset: assert property (@(posedge ref_clk) disable iff (srst)
    $past(srst) |-> sp_out == `STK_SP_RESET)
    else $error("pointer reset value wrong");

  // Push addresses the free word the pointer names
  a_push_addr: assert property (@(posedge ref_clk) disable iff (srst)
    (op == op_push) |-> effective_address == sp_out)
    else $error("push address wrong");

  // Pop addresses the word below the pointer
  a_pop_addr: assert property (@(posedge ref_clk) disable iff (srst)
    (op == op_pop) |-> effective_address == sp_out - `STK_WORD_STEP)
    else $error("pop address wrong");

  // Plain access adds the offset to the pointer
  a_access_addr: assert property (@(posedge ref_clk) disable iff (srst)
    (op == op_access) |-> effective_address == sp_out + offset)
    else $error("access address wrong");

  // Address beyond the limit traps in the same cycle
  a_over_trap: assert property (@(posedge ref_clk) disable iff (srst)
    (addr_valid && effective_address > limit_out) |-> stack_trap)
    else $error("address over limit did not trap");

  // A trap always has an over-limit or under-floor cause
  a_trap_cause: assert property (@(posedge ref_clk) disable iff (srst)
    stack_trap |-> (effective_address > limit_out || effective_address < `STK_FLOOR))
    else $error("trap without cause");

  // Pointer write lands word aligned and beats push or pop
  a_sp_write: assert property (@(posedge ref_clk) disable iff (srst)
    sp_wr |=> sp_out == {$past(wr_data[`STK_WIDTH-1:1]), 1'b0})
    else $error("pointer write wrong");

  // Limit write lands word aligned
  a_limit_write: assert property (@(posedge ref_clk) disable iff (srst)
    limit_wr |=> limit_out == {$past(wr_data[`STK_WIDTH-1:1]), 1'b0})
    else $error("limit write wrong");

  // Pointer rests when nothing moves it
  a_sp_hold: assert property (@(posedge ref_clk) disable iff (srst)
    (op == op_none && !sp_wr) |=> $stable(sp_out))
    else $error("pointer moved while idle");

  // Idle cycles never request a trap
  a_idle_quiet: assert property (@(posedge ref_clk) disable iff (srst)
    !addr_valid |-> !stack_trap)
    else $error("trap while idle");
endmodule // stack_pointer_limit_checker

// ==== hdl/stack_params.svh ====
/*
  Constants for the stack pointer limit checker: widths, floor address, pointer reset value.
  Assumes inclusion by bare name from the design files.
*/
`ifndef STACK_PARAMS_SVH
`define STACK_PARAMS_SVH
`define STK_WIDTH 16
`define STK_FLOOR 16'h0800
`define STK_WORD_STEP 16'h0002
`define STK_SP_RESET 16'h0800
`define STK_PC_MSB_LO 16
`define STK_PC_MSB_HI 23
`endif

// ==== hdl/stack_pkg.sv ====
/*
  Types shared by the stack pointer limit checker.
  Assumes stack_params.svh is on the include path.
*/
`include "stack_params.svh"
package stack_pkg;
  typedef logic [`STK_WIDTH-1:0] word_t;
  typedef enum logic [1:0] {op_none, op_push, op_pop, op_access} stack_op_t;
endpackage : stack_pkg

// ==== hdl/stack_bound_check.sv ====
/*
  Combinational comparison of a stack address against the limit and the fixed floor.
  Assumes the limit is already word aligned.
*/
`include "stack_params.svh"
module stack_bound_check
(
  input wire stack_pkg::word_t addr, // Address under test
  input wire stack_pkg::word_t limit, // Upper boundary
  output logic over_limit, // Address above limit
  output logic under_floor // Address below floor
);
  import stack_pkg::*;

  // Both comparisons are unsigned
  assign over_limit = addr > limit;
  assign under_floor = addr < `STK_FLOOR;
endmodule // stack_bound_check

// ==== sim/trap_sink.sv ====
/*
  Trap logic model: counts the cycles in which a stack trap is requested.
  Assumes the trap request is a level sampled on each rising ref_clk.
*/
module trap_sink (
  input wire ref_clk, // CPU clock
  input wire srst, // Sync reset
  input wire stack_trap, // Trap request
  output logic [7:0] trap_count // Traps taken
);
  timeunit 1ns;
  timeprecision 1ns;
  // Take one trap for each requesting cycle
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      trap_count <= 8'h00;
    else if (stack_trap)
      trap_count <= trap_count + 8'h01;
  end
endmodule // trap_sink

// ==== sim/stack_pointer_limit_checker_tb_top.sv ====
/*
  Self-checking bench for the stack pointer limit checker.
  Assumes inputs change 10 ns after the rising edge and comb outputs settle in 1 ns.
*/
module stack_pointer_limit_checker_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import stack_pkg::*;
  logic ref_clk = 1'b0, srst = 1'b1, call = 1'b0, exc = 1'b0, sp_wr = 1'b0, lim_wr = 1'b0;
  stack_op_t op = op_none;
  word_t offset = 16'h0000, wr_data = 16'h0000, ea, sp, lim;
  logic [23:0] pcd;
  logic [7:0] traps;
  logic av, trap;
  int err_total = 0, n_compared = 0;
  always #50 ref_clk = ~ref_clk;
  stack_pointer_limit_checker DUT (.ref_clk(ref_clk), .srst(srst), .op(op), .offset(offset),
    .pc_push_call(call), .pc_push_exc(exc), .pc_in(24'hAB1234), .status_low_byte(8'h5A),
    .sp_wr(sp_wr), .limit_wr(lim_wr), .wr_data(wr_data), .effective_address(ea),
    .addr_valid(av), .pc_push_data(pcd), .sp_out(sp), .limit_out(lim), .stack_trap(trap));
  trap_sink model (.ref_clk(ref_clk), .srst(srst), .stack_trap(trap), .trap_count(traps));
  // Compare and count
  task chk(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task tick;
    @(posedge ref_clk);
    #10;
  endtask
  // One-cycle write of the limit (sel=1) or the pointer
  task wr(input logic sel, input word_t d);
    lim_wr = sel;
    sp_wr = !sel;
    wr_data = d;
    tick;
    lim_wr = 1'b0;
    sp_wr = 1'b0;
    tick;
  endtask
  // One stack operation, judged in its own cycle
  task stk(input stack_op_t o, input word_t e, input logic t);
    op = o;
    #1;
    chk(24'(ea), 24'(e));
    chk(24'(trap), 24'(t));
    chk(24'(av), 24'h000001);
    tick;
  endtask
  task t_align;
    wr(1'b1, 16'h0803);
    chk(24'(lim), 24'h000802);
    wr(1'b0, 16'h0801);
    chk(24'(sp), 24'h000800);
  endtask
  task t_pc;
    call = 1'b1;
    op = op_push;
    #1;
    chk(pcd, 24'h001234);
    exc = 1'b1;
    #1;
    chk(pcd, 24'h5A1234);
    tick;
    call = 1'b0;
    exc = 1'b0;
    op = op_none;
  endtask
  task t_push;
    wr(1'b0, 16'h0800);
    wr(1'b1, 16'h0802);
    offset = 16'h0002;
    stk(op_access, 16'h0802, 1'b0);
    stk(op_push, 16'h0800, 1'b0);
    stk(op_push, 16'h0802, 1'b0);
    stk(op_push, 16'h0804, 1'b1);
    op = op_none;
    #1;
    chk(24'(av), 24'h000000);
    chk(24'(sp), 24'h000806);
  endtask
  // Pointer writes precede pops, never a limit write
  task t_pop;
    wr(1'b0, 16'h0804);
    stk(op_pop, 16'h0802, 1'b0);
    stk(op_pop, 16'h0800, 1'b0);
    stk(op_pop, 16'h07FE, 1'b1);
    op = op_none;
    chk(24'(sp), 24'h0007FE);
  endtask
  initial
  begin
    repeat (6) @(posedge ref_clk);
    #10 srst = 1'b0;
    chk(24'(sp), 24'h000800);
    t_align;
    t_pc;
    t_push;
    t_pop;
    tick;
    chk(24'(traps), 24'h000002);
    final_report;
  end
  // Cut a hang short
  initial
  begin
    #20000;
    err_total++;
    final_report;
  end
endmodule // stack_pointer_limit_checker_tb_top
